// ### pkg/ssa_link_if.sv
// Four-wire SPI link between host end and device end
interface ssa_link_if;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic miso;
  // Host drives select, clock and data out
  modport host (output sel_n, output sclk, output mosi, input miso);
  // Device answers on miso only
  modport device (input sel_n, input sclk, input mosi, output miso);
endinterface

// ### pkg/ssa_pkg.sv
// Shared constants and types of the SRAM-access SPI link, both ends
package ssa_pkg;
  // Timing of the link clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Frame buffer geometry
  localparam int BUF_DEPTH = 128;
  localparam int BUF_ADDR_W = 7;
  // Command byte layout
  localparam logic [2:0] CMD_SRAM_READ = 3'h0;
  localparam logic [2:0] CMD_SRAM_WRITE = 3'h2;
  localparam int CMD_REG_BIT = 7;
  localparam int CMD_REG_WR_BIT = 6;
  // Device register addresses
  localparam logic [5:0] REG_CTRL_ONE = 6'h04;
  localparam logic [5:0] REG_PART_NUMBER = 6'h1c;
  localparam logic [5:0] REG_VERSION_NUMBER = 6'h1d;
  localparam logic [5:0] REG_MAKER_CODE_LOW = 6'h1e;
  localparam logic [5:0] REG_MAKER_CODE_HIGH = 6'h1f;
  // Control register reset and field positions
  localparam logic [7:0] CTRL_ONE_RESET = 8'h20;
  localparam int CTRL_SRC_LSB = 2;
  localparam logic [7:0] STATUS_ECHO_RESET = 8'h00;
  // Sources of the first returned byte
  typedef enum logic [1:0] {
    SSA_SRC_ZERO = 2'b00,
    SSA_SRC_STATE = 2'b01,
    SSA_SRC_STRENGTH = 2'b10,
    SSA_SRC_IRQ = 2'b11
  } ssa_src_type;
  // Host register offsets and fields
  localparam logic [3:0] HOST_REG_TX = 4'h0;
  localparam logic [3:0] HOST_REG_RX = 4'h4;
  localparam logic [3:0] HOST_REG_STATUS = 4'h8;
  localparam int HOST_KEEP_BIT = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Host link sequencer states
  typedef enum logic [2:0] {
    SSA_ST_IDLE = 3'b000,
    SSA_ST_LOW = 3'b001,
    SSA_ST_HIGH = 3'b010,
    SSA_ST_TRAIL = 3'b011,
    SSA_ST_GAP = 3'b100
  } ssa_state_type;
endpackage

// ### rtl/ssa_device_end.sv
// Device end: SPI slave with SRAM random access, status byte and id registers
module ssa_device_end
  import ssa_pkg::*;
#(
  // Identity values, arbitrary
  parameter logic [7:0] PART_NUMBER_VALUE = 8'h5a,
  parameter logic [7:0] VERSION_NUMBER_VALUE = 8'h01,
  parameter logic [7:0] MAKER_CODE_LOW_VALUE = 8'h6b,
  parameter logic [7:0] MAKER_CODE_HIGH_VALUE = 8'h93,
  parameter int DEPTH = BUF_DEPTH
) (
  // System
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Link to the host
  ssa_link_if.device link,
  // Radio-side registers mirrored in the status byte
  input wire logic [7:0] transceiver_state_reg_i,
  input wire logic [7:0] signal_strength_reg_i,
  input wire logic [7:0] irq_status_reg_i,
  // Control register as seen by the radio
  output logic [7:0] transceiver_control_one_o,
  // Access violation interrupt of the random access path
  output logic buffer_access_violation_irq_o
);

  // Synchroniser chains: [0] meta, [1] stable, [2] edge history on select and clock only
  logic [2:0] sel_sync;
  logic [2:0] sclk_sync;
  logic [1:0] mosi_sync;

  // Link framing state
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] cmd;
  logic [BUF_ADDR_W-1:0] addr;

  // Payload store; the length byte lives elsewhere
  logic [7:0] frame_payload [DEPTH];

  // Decoded strobes
  logic sel_active;
  logic sel_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic is_reg;
  logic is_sram_rd;
  logic is_sram_wr;
  logic [7:0] next_byte;

  // Status byte chosen by the source field
  function automatic logic [7:0] status_echo_byte(input logic [7:0] ctrl,
                                                  input logic [7:0] state_v,
                                                  input logic [7:0] rssi_v,
                                                  input logic [7:0] irq_v);
    ssa_src_type src;
    src = ssa_src_type'(ctrl[CTRL_SRC_LSB+1:CTRL_SRC_LSB]);
    case (src)
      SSA_SRC_ZERO: status_echo_byte = STATUS_ECHO_RESET;
      SSA_SRC_STATE: status_echo_byte = state_v;
      SSA_SRC_STRENGTH: status_echo_byte = rssi_v;
      SSA_SRC_IRQ: status_echo_byte = irq_v;
      default: status_echo_byte = STATUS_ECHO_RESET;
    endcase
  endfunction

  // Register read decode; unknown addresses read zero
  function automatic logic [7:0] reg_read(input logic [5:0] a,
                                          input logic [7:0] ctrl);
    case (a)
      REG_CTRL_ONE: reg_read = ctrl;
      REG_PART_NUMBER: reg_read = PART_NUMBER_VALUE;
      REG_VERSION_NUMBER: reg_read = VERSION_NUMBER_VALUE;
      REG_MAKER_CODE_LOW: reg_read = MAKER_CODE_LOW_VALUE;
      REG_MAKER_CODE_HIGH: reg_read = MAKER_CODE_HIGH_VALUE;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Two flops on every pin before use
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sel_sync <= 3'h7;
      sclk_sync <= 3'h0;
      mosi_sync <= 2'h0;
    end else begin
      sel_sync <= {sel_sync[1:0], link.sel_n};
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      mosi_sync <= {mosi_sync[0], link.mosi};
    end
  end

  // Edges seen on the stable stages only
  assign sel_active = ~sel_sync[1];
  assign sel_fall = ~sel_sync[1] & sel_sync[2];
  assign sclk_rise = sel_active & sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = sel_active & ~sclk_sync[1] & sclk_sync[2];
  assign rx_byte = {rx_shift[6:0], mosi_sync[1]};
  assign byte_done = sclk_rise && (bit_cnt == 3'h7);

  // Command classes
  // read and write codes
  assign is_sram_rd = (cmd[7:5] == CMD_SRAM_READ);
  assign is_sram_wr = (cmd[7:5] == CMD_SRAM_WRITE);
  assign is_reg = cmd[CMD_REG_BIT];

  // Bit counter restarts whenever select is high
  // partial byte dropped
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !sel_active) begin
      bit_cnt <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Mosi sampled on the rising link edge, mode 0
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_shift <= 8'h00;
    end else if (sclk_rise) begin
      rx_shift <= rx_byte;
    end
  end

  // Byte position in the access, saturates at the data phase
  // first byte is the command
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !sel_active) begin
      byte_cnt <= 2'h0;
    end else if (byte_done && byte_cnt != 2'h2) begin
      byte_cnt <= byte_cnt + 2'h1;
    end
  end

  // Command byte capture
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmd <= 8'h00;
    end else if (byte_done && byte_cnt == 2'h0) begin
      cmd <= rx_byte;
    end
  end

  // Address counter; top bit of the address byte is ignored
  // seven-bit start address
  // wraps silently, host keeps in range
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr <= '0;
    end else if (byte_done && !is_reg && (is_sram_rd || is_sram_wr)) begin
      if (byte_cnt == 2'h1) begin
        addr <= rx_byte[BUF_ADDR_W-1:0];
      end else if (byte_cnt == 2'h2) begin
        addr <= addr + 1'b1;
      end
    end
  end

  // Payload writes happen only on a complete eighth bit
  // store at current address
  always_ff @(posedge clk_sys_i) begin
    if (byte_done && byte_cnt == 2'h2 && is_sram_wr) begin
      frame_payload[addr] <= rx_byte;
    end
  end

  // Control register, written by a register write to its address
  // read-write control register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      transceiver_control_one_o <= CTRL_ONE_RESET;
    end else if (byte_done && byte_cnt == 2'h1 && is_reg && cmd[CMD_REG_WR_BIT]
                 && cmd[5:0] == REG_CTRL_ONE) begin
      transceiver_control_one_o <= rx_byte;
    end
  end

  // Byte to load at the next byte boundary
  // buffer data from third byte
  always_comb begin
    next_byte = 8'h00;
    if (byte_cnt == 2'h1 && is_reg && !cmd[CMD_REG_WR_BIT]) begin
      next_byte = reg_read(cmd[5:0], transceiver_control_one_o);
    end else if (byte_cnt == 2'h2 && !is_reg && is_sram_rd) begin
      next_byte = frame_payload[addr];
    end
  end

  // Miso shifter: status loaded at select fall, shifts on falling edge
  // status byte first
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !sel_active) begin
      tx_shift <= 8'h00;
    end else if (sel_fall) begin
      tx_shift <= status_echo_byte(transceiver_control_one_o, transceiver_state_reg_i,
                                   signal_strength_reg_i, irq_status_reg_i);
    end else if (sclk_fall) begin
      // Count back at zero marks a finished byte
      if (bit_cnt == 3'h0) begin
        tx_shift <= next_byte;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Msb of the shifter is the pin, straight from a flop
  assign link.miso = tx_shift[7];

  // Random access never reports violations
  // interrupt held low
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      buffer_access_violation_irq_o <= 1'b0;
    end else begin
      buffer_access_violation_irq_o <= 1'b0;
    end
  end

  // Filler bytes on mosi are simply not decoded
  // filler ignored

endmodule

// ### rtl/ssa_host_end.sv
// Host end: AXI4-Lite controlled SPI master, one byte per order
//
// Added by the designer: the AXI4-Lite slave port.
module ssa_host_end
  import ssa_pkg::*;
#(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  // System
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // AXI4-Lite write channels
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Link to the device
  ssa_link_if.host link
);

  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic start;
  logic busy;
  logic [1:0] miso_sync;
  ssa_state_type state;
  logic [15:0] timer;
  logic half_up;
  logic [2:0] bit_cnt;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic keep;
  logic sel_n;
  logic sclk;
  logic mosi;

  // Offset decode shared by both directions
  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == HOST_REG_TX) || (a == HOST_REG_RX) || (a == HOST_REG_STATUS);
  endfunction

  assign busy = (state != SSA_ST_IDLE);
  assign do_write = aw_got && w_got && !s_axi_bvalid_o;
  // Only a byte order to an idle sequencer is taken
  assign start = do_write && aw_addr == HOST_REG_TX && w_strb[0] && !busy;
  assign half_up = (timer == 16'(HALF_CYCLES - 1));

  // Write address and data taken in either order
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Busy or unmapped orders are refused with an error
        s_axi_bresp_o <= (start || (mapped(aw_addr) && aw_addr != HOST_REG_TX))
                         ? AXI_OKAY : AXI_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= AXI_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= mapped(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
      case (s_axi_araddr_i)
        HOST_REG_TX: s_axi_rdata_o <= {23'h0, keep, tx_sh};
        HOST_REG_RX: s_axi_rdata_o <= {24'h0, rx_byte};
        HOST_REG_STATUS: s_axi_rdata_o <= {30'h0, ~sel_n, busy};
        default: s_axi_rdata_o <= 32'h0;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Miso comes from another domain
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      miso_sync <= 2'h0;
    end else begin
      miso_sync <= {miso_sync[0], link.miso};
    end
  end

  // Mode 0 sequencer; select may stay low between bytes
  // select low, command first
  // mosi always at a valid level
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= SSA_ST_IDLE;
      timer <= 16'h0;
      bit_cnt <= 3'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      rx_byte <= 8'h00;
      keep <= 1'b0;
      sel_n <= 1'b1;
      sclk <= 1'b0;
      mosi <= 1'b0;
    end else begin
      timer <= half_up ? 16'h0 : timer + 16'h1;
      case (state)
        SSA_ST_IDLE: begin
          timer <= 16'h0;
          if (start) begin
            tx_sh <= w_data[7:0];
            keep <= w_data[HOST_KEEP_BIT];
            mosi <= w_data[7];
            sel_n <= 1'b0;
            bit_cnt <= 3'h0;
            state <= SSA_ST_LOW;
          end
        end
        SSA_ST_LOW: if (half_up) begin
          sclk <= 1'b1;
          rx_sh <= {rx_sh[6:0], miso_sync[1]};
          state <= SSA_ST_HIGH;
        end
        SSA_ST_HIGH: if (half_up) begin
          sclk <= 1'b0;
          if (bit_cnt == 3'h7) begin
            rx_byte <= rx_sh;
            state <= SSA_ST_TRAIL;
          end else begin
            bit_cnt <= bit_cnt + 3'h1;
            tx_sh <= {tx_sh[6:0], 1'b0};
            mosi <= tx_sh[6];
            state <= SSA_ST_LOW;
          end
        end
        SSA_ST_TRAIL: if (keep) begin
          state <= SSA_ST_IDLE;
        end else if (half_up) begin
          sel_n <= 1'b1;
          state <= SSA_ST_GAP;
        end
        // Gap lets the device see select high
        SSA_ST_GAP: if (half_up) begin
          state <= SSA_ST_IDLE;
        end
        default: state <= SSA_ST_IDLE;
      endcase
    end
  end

  assign link.sel_n = sel_n;
  assign link.sclk = sclk;
  assign link.mosi = mosi;

endmodule

// ### verification/spi_sram_status_id_access_bench.sv
// Bench: host end and device end joined over the link, driven over AXI4-Lite
module spi_sram_status_id_access_bench import ssa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Identity values, arbitrary
  localparam logic [7:0] ID_V [4] = '{8'h3c, 8'h17, 8'h4e, 8'h25};
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] val;
    logic [1:0] resp;
  } ssa_note_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] st_reg = 8'h00;
  logic [7:0] rssi_reg = 8'h00;
  logic [7:0] irq_reg = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, viol_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_m = 8'h20;
  logic [7:0] mem_m [128];
  logic [31:0] seed = 32'h8e9a37cc;
  logic [31:0] r;
  logic [31:0] d;
  int err_count = 0;
  int n_compared = 0;
  ssa_note_type rq [$];
  ssa_note_type note;
  logic [1:0] bq [$];

  ssa_link_if i_ssa_link_if ();

  ssa_host_end #(.HALF_CYCLES(SCLK_HALF_CYCLES)) i_ssa_host_end (
    .clk_sys_i(clk), .srst_i(srst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .link(i_ssa_link_if)
  );

  ssa_device_end #(
    .PART_NUMBER_VALUE(ID_V[0]), .VERSION_NUMBER_VALUE(ID_V[1]),
    .MAKER_CODE_LOW_VALUE(ID_V[2]), .MAKER_CODE_HIGH_VALUE(ID_V[3]), .DEPTH(BUF_DEPTH)
  ) i_ssa_device_end (
    .clk_sys_i(clk), .srst_i(srst), .link(i_ssa_link_if),
    .transceiver_state_reg_i(st_reg), .signal_strength_reg_i(rssi_reg),
    .irq_status_reg_i(irq_reg), .transceiver_control_one_o(ctrl_one),
    .buffer_access_violation_irq_o(viol_irq)
  );

  ssa_link_properties #(.HALF_CYCLES(SCLK_HALF_CYCLES)) i_ssa_link_properties (
    .clk_sys_i(clk), .srst_i(srst), .sel_n(i_ssa_link_if.sel_n),
    .sclk(i_ssa_link_if.sclk), .mosi(i_ssa_link_if.mosi), .miso(i_ssa_link_if.miso)
  );

  // System clock, 100 MHz
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Answers are matched in order against the notes left by the drivers
  always @(posedge clk) begin
    if (rvalid && rready) begin
      note = rq.pop_front();
      check("rdata", note.val & note.mask, rdata & note.mask);
      check("rresp", 32'(note.resp), 32'(rresp));
    end
    if (bvalid && bready) begin
      check("bresp", 32'(bq.pop_front()), 32'(bresp));
    end
  end

  // Write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    bq.push_back(er);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input ssa_note_type n, output logic [31:0] v);
    rq.push_back(n);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rready <= 1'b0;
  endtask

  // One link byte: order it, poll until idle, fetch what came back
  task automatic xfer(input logic [7:0] tx, input logic keep, input logic [7:0] ex,
                      input logic care);
    logic [31:0] v;
    axi_wr(HOST_REG_TX, {23'h0, keep, tx}, AXI_OKAY);
    for (int k = 0; k < 100; k++) begin
      axi_rd(HOST_REG_STATUS, {32'h0, 32'h0, AXI_OKAY}, v);
      if (v[0] === 1'b0) break;
    end
    check("select_held", 32'(keep), 32'(v[1]));
    axi_rd(HOST_REG_RX, {care ? 32'hff : 32'h0, 24'h0, ex, AXI_OKAY}, v);
  endtask

  function automatic logic [7:0] status_exp();
    case (ctrl_m[3:2])
      2'h1: return st_reg;
      2'h2: return rssi_reg;
      2'h3: return irq_reg;
      default: return 8'h00;
    endcase
  endfunction

  task automatic reg_acc(input logic wr, input logic [5:0] a, input logic [7:0] v,
                         input logic [7:0] ex);
    xfer({1'b1, wr, a}, 1'b1, status_exp(), 1'b1);
    xfer(v, 1'b0, ex, !wr);
    if (wr && a == REG_CTRL_ONE) ctrl_m = v;
  endtask

  // Random buffer access; reserved command bits and filler data are random
  task automatic sram_acc(input logic wr, input logic [6:0] a, input int n);
    logic [31:0] x;
    x = xs();
    xfer({1'b0, wr, 1'b0, x[4:0]}, 1'b1, status_exp(), 1'b1);
    xfer({1'b0, a}, 1'b1, 8'h00, 1'b0);
    for (int i = 0; i < n; i++) begin
      x = xs();
      if (wr) mem_m[a + i] = x[7:0];
      xfer(x[7:0], i != n - 1, mem_m[a + i], !wr);
    end
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    reg_acc(1'b0, REG_CTRL_ONE, 8'h00, 8'h20);
    check("control_out", 32'h20, 32'(ctrl_one));
    reg_acc(1'b1, REG_PART_NUMBER, 8'hff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_acc(1'b0, REG_PART_NUMBER + 6'(i), 8'h00, ID_V[i]);
    end
    for (int s = 0; s < 4; s++) begin
      r = xs();
      st_reg <= r[7:0];
      rssi_reg <= r[15:8];
      irq_reg <= r[23:16];
      @(posedge clk);
      reg_acc(1'b1, REG_CTRL_ONE, {r[31:28], 2'(s), r[25:24]}, 8'h00);
      check("control_out", 32'(ctrl_m), 32'(ctrl_one));
      reg_acc(1'b0, REG_CTRL_ONE, 8'h00, ctrl_m);
    end
    // accesses stop at the last location
    sram_acc(1'b1, 7'h7c, 4);
    sram_acc(1'b0, 7'h7c, 4);
    sram_acc(1'b1, 7'h10, 3);
    sram_acc(1'b0, 7'h11, 2);
    // Unmapped offset and an order while busy are both refused
    axi_rd(4'hc, {32'hffffffff, 32'h0, AXI_SLVERR}, d);
    // Unmapped write refused, write to the receive word ignored
    axi_wr(4'hc, 32'h0, AXI_SLVERR);
    axi_wr(HOST_REG_RX, 32'h1ff, AXI_OKAY);
    axi_wr(HOST_REG_TX, 32'h0, AXI_OKAY);
    axi_wr(HOST_REG_TX, 32'h0, AXI_SLVERR);
    repeat (200) @(posedge clk);
    check("access_irq", 32'h0, 32'(viol_irq));
    give_verdict();
  end
endmodule

// ### verification/ssa_link_properties.sv
// Concurrent checks on the SPI link between host end and device end
module ssa_link_properties #(
  parameter int HALF_CYCLES = 8
) (
  // System
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Link wires
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RISE_LIM = HALF_CYCLES + 1;
  logic [7:0] high_len;
  logic [9:0] rise_cnt;
  logic sclk_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // Length of the current high phase of the link clock
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !sclk) begin
      high_len <= 8'h00;
    end else begin
      high_len <= high_len + 8'h01;
    end
  end

  // Clock rises within one select-low period, whole bytes only
  always_ff @(posedge clk_sys_i) begin
    sclk_q <= sclk;
    if (srst_i || sel_n) begin
      rise_cnt <= 10'h000;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 10'h001;
    end
  end

  // Select falls with the clock parked low
  sequence s_open;
    $fell(sel_n) ##0 !sclk;
  endsequence
  // Byte finished: clock low for the last three samples
  sequence s_quiet;
    !sclk && !$past(sclk) && !$past(sclk, 2);
  endsequence

  AST_IDLE_CLOCK: assert property (sel_n |-> !sclk)
    else $error("link clock moved while deselected");
  AST_FIRST_EDGE: assert property (s_open |-> (!sclk)[*2] ##[1:RISE_LIM] $rose(sclk))
    else $error("first clock rise not in time after select");
  AST_HIGH_WIDTH: assert property ($fell(sclk) |-> high_len == 8'(HALF_CYCLES))
    else $error("link clock high phase has wrong length");
  AST_WHOLE_BYTES: assert property ($rose(sel_n) |-> rise_cnt[2:0] == 3'h0 && rise_cnt != 10'h0)
    else $error("select released after a partial byte");
  AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
    else $error("host data changed while clock high");
  AST_MISO_HOLD: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("device data changed while clock high");
  AST_SEL_RELEASE: assert property ($rose(sel_n) |-> s_quiet)
    else $error("select released too close to a clock edge");
  AST_SEL_GAP: assert property ($rose(sel_n) |-> sel_n[*3])
    else $error("select high for too short a gap");
  AST_MISO_IDLE: assert property (sel_n[*6] |-> !miso)
    else $error("device drives data while deselected");
endmodule
